// File: src/cfm_fault_mode_ctrl.sv
// Operation
// RQ1: Sixteen consecutive current-limit cycles latch fault
// RQ2: Over-current latches even during soft-start
// RQ3: Latched fault clears only via new soft-start
// RQ4: Discharge low-side below 0.25V, re-arm above 0.5V
// RQ5: Sixteen consecutive under-voltage cycles latch fault
// RQ6: Under-voltage blocked during soft-start
// RQ7: Two consecutive over-voltage cycles latch fault
// RQ8: Phase high with low-side on latches immediately
// RQ9: Over-voltage and short act during soft-start
// RQ10: Sink enable pin to 1.1V, then pull-up
// RQ11: Enable above 1.35V starts new soft-start
// RQ12: External enable network chooses restart behaviour
// RQ13: Hold enable high to prevent auto restart
// RQ14: Fault at 160C, restart below 130C
// RQ15: Power-good low when feedback out of window
// RQ16: Power-good low until fault latch armed
// RQ17: Eight light-load cycles enter skip mode
// RQ18: Skip pulse launched at reference crossing
// RQ19: Force sink after 40us without pulse
// RQ20: Leave skip mode on 1.5% droop
// RQ21: Pulse-only select disables skip mode
// RQ22: Fault latch, skip inhibited below ramp 1.0V
// RQ23: Lockout or enable toggle resets, discharges ramp
// RQ24: Only discharge switching while fault latched
`timescale 1ns/1ps

module cfm_fault_mode_ctrl
    import cfm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Comparator bundle
    input  wire cfm_cmp_t   cmp,
    // Power stage control
    output logic            switchEnable,
    output logic            lowSideDischarge,
    output logic            rampDischarge,
    // Fault status
    output logic            faultLatch,
    output cfm_cause_t      faultCause,
    output logic            faultArmed,
    // Enable pin network
    output logic            turnOnSinkEnable,
    output logic            turnOnPullupEnable,
    // Power-good open-drain pin
    output logic            powerGoodFlagOut,
    output logic            powerGoodFlagOe,
    // Light-load skip mode
    output logic            skipMode,
    output logic            skipPulseLaunch,
    output logic            skipForceSink
);

    cfm_state_t             state;
    cfm_state_t             next_state;
    logic                   enPresent;
    logic                   otHold;
    logic                   ilimHit;
    logic                   uvHit;
    logic                   ovHit;
    logic                   lightHit;
    logic                   shortNow;
    logic                   tripArmed;
    logic                   tripAlways;
    logic                   trip;
    logic                   logicReset;
    logic                   fbBelowRefPrev;
    logic                   refCross;
    logic [SKIP_TMR_W-1:0]  skipTimer;
    logic                   skipTimeout;

    localparam logic [SKIP_TMR_W-1:0] SKIP_LIMIT = SKIP_TMR_W'(SKIP_TIMEOUT_CYC);

    // True in the states where the converter is allowed to switch normally
    function automatic logic is_switching(input cfm_state_t s);
        return (s == ST_SOFTSTART) || (s == ST_RUN);
    endfunction

    // True in the states where the latched fault is still being served
    function automatic logic is_latched(input cfm_state_t s);
        return (s == ST_FAULT) || (s == ST_REARM);
    endfunction

    // Supply lockout synchronously resets the sequencer and its outputs except the skip pulse requests; the enable and thermal holds keep their state
    assign logicReset = cmp.supplyLockout; // RQ23

    // Enable level with the pin's own hysteresis between 1.1 V and 1.35 V
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enPresent <= 1'b0;
        end else if (cmp.turnOnAbove) begin
            enPresent <= 1'b1; // RQ11
        end else if (cmp.turnOnBelow) begin
            enPresent <= 1'b0; // RQ10
        end
    end

    // Thermal hold: set hot, released only once the die has cooled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otHold <= 1'b0;
        end else if (cmp.overTemp) begin
            otHold <= 1'b1; // RQ14
        end else if (cmp.tempRecovered) begin
            otHold <= 1'b0; // RQ14
        end
    end

    // Current limit counted per switching cycle, not per clock
    cfm_consec #(
        .COUNT  (ILIM_CYCLES)
    ) u_ilim (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (!is_switching(state)),
        .sample (cmp.cycleEnd),
        .cond   (cmp.currentLimit),
        .hit    (ilimHit)
    ); // RQ1

    // Under-voltage run, counted only once the fault latch is armed
    cfm_consec #(
        .COUNT  (UV_CYCLES)
    ) u_uv (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (state != ST_RUN),
        .sample (1'b1),
        .cond   (cmp.fbUnder),
        .hit    (uvHit)
    ); // RQ5 RQ6

    // Over-voltage run of two clocks filters single-cycle glitches
    cfm_consec #(
        .COUNT  (OV_CYCLES)
    ) u_ov (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (!is_switching(state)),
        .sample (1'b1),
        .cond   (cmp.fbOver),
        .hit    (ovHit)
    ); // RQ7

    // Light-load run that qualifies skip-mode entry
    cfm_consec #(
        .COUNT  (LIGHT_CYCLES)
    ) u_light (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (state != ST_RUN),
        .sample (1'b1),
        .cond   (cmp.lightLoad),
        .hit    (lightHit)
    ); // RQ17

    // Shorted high side has no filter: a real short must stop at once
    assign shortNow   = cmp.phaseHigh && cmp.lowSideFullOn; // RQ8

    // Faults that may act during soft-start
    assign tripAlways = ilimHit || ovHit || shortNow; // RQ2 RQ9

    // Faults blanked until the ramp has armed the latch
    assign tripArmed  = uvHit || cmp.overTemp; // RQ6 RQ22

    assign trip = is_switching(state) && (tripAlways || ((state == ST_RUN) && tripArmed));

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                // New soft-start only with enable high and die cool
                if (enPresent && !otHold) begin
                    next_state = ST_SOFTSTART; // RQ11 RQ14
                end
            end
            ST_SOFTSTART: begin
                if (!enPresent) begin
                    next_state = ST_OFF; // RQ23
                end else if (trip) begin
                    next_state = ST_FAULT;
                end else if (cmp.rampAbove1v0) begin
                    next_state = ST_RUN; // RQ22
                end
            end
            ST_RUN: begin
                if (!enPresent) begin
                    next_state = ST_OFF; // RQ23
                end else if (trip) begin
                    next_state = ST_FAULT;
                end
            end
            ST_FAULT: begin
                // Stays here for good if the pin is held high externally
                if (!enPresent) begin
                    next_state = ST_REARM; // RQ10 RQ13
                end
            end
            ST_REARM: begin
                // Pull-up back on; wait for the pin to charge past 1.35 V
                if (enPresent && !otHold) begin
                    next_state = ST_OFF; // RQ3 RQ11
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= STATE_RESET;
        end else if (logicReset) begin
            state <= ST_OFF; // RQ23
        end else begin
            state <= next_state;
        end
    end

    // Fault latch; cleared only by lockout or a full enable cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultLatch <= 1'b0;
        end else if (logicReset) begin
            faultLatch <= 1'b0; // RQ23
        end else begin
            faultLatch <= is_latched(next_state); // RQ3
        end
    end

    // Sticky cause bits, cleared with the next soft-start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultCause <= CAUSE_RESET;
        end else if (logicReset || (next_state == ST_SOFTSTART)) begin
            faultCause <= CAUSE_RESET;
        end else if (trip) begin
            faultCause.overCurrent   <= ilimHit;
            faultCause.underVoltage  <= (state == ST_RUN) && uvHit;
            faultCause.overVoltage   <= ovHit;
            faultCause.highSideShort <= shortNow;
            faultCause.overTemp      <= (state == ST_RUN) && cmp.overTemp;
        end
    end

    // Armed flag mirrors the end of the soft-start window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultArmed <= 1'b0;
        end else begin
            faultArmed <= !logicReset && (next_state == ST_RUN); // RQ22
        end
    end

    // Gate drive permission; nothing switches while the latch is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switchEnable <= 1'b0;
        end else begin
            switchEnable <= !logicReset && is_switching(next_state); // RQ24
        end
    end

    // Output discharge with 0.25 V / 0.5 V hysteresis avoids undershoot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowSideDischarge <= 1'b0;
        end else if (logicReset || !is_latched(next_state)) begin
            lowSideDischarge <= 1'b0; // RQ24
        end else if (!is_latched(state)) begin
            lowSideDischarge <= !cmp.fbBelowDisch; // RQ4
        end else if (cmp.fbBelowDisch) begin
            lowSideDischarge <= 1'b0; // RQ4
        end else if (cmp.fbAboveRedisch) begin
            lowSideDischarge <= 1'b1; // RQ4
        end
    end

    // Startup ramp held discharged whenever the sequencer is in neither soft-start nor run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rampDischarge <= 1'b1;
        end else begin
            rampDischarge <= logicReset || !is_switching(next_state); // RQ23
        end
    end

    // Enable pin: sink after a fault until 1.1 V, pull-up otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            turnOnSinkEnable   <= 1'b0;
            turnOnPullupEnable <= 1'b1;
        end else begin
            turnOnSinkEnable   <= !logicReset && (next_state == ST_FAULT); // RQ10
            turnOnPullupEnable <= logicReset || (next_state != ST_FAULT); // RQ10
        end
    end

    // Power-good pulls low until armed and whenever out of window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerGoodFlagOe <= 1'b1;
        end else begin
            powerGoodFlagOe <= logicReset || (next_state != ST_RUN) // RQ16
                            || cmp.fbOutOfWindow; // RQ15
        end
    end

    // Open drain only ever drives low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerGoodFlagOut <= 1'b0;
        end else begin
            powerGoodFlagOut <= 1'b0;
        end
    end

    // Skip mode: enter on light load, leave on droop or forced PWM
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skipMode <= 1'b0;
        end else if (logicReset || (next_state != ST_RUN)) begin
            skipMode <= 1'b0; // RQ22
        end else if (cmp.pulseOnly) begin
            skipMode <= 1'b0; // RQ21
        end else if (skipMode && cmp.fbDroop) begin
            skipMode <= 1'b0; // RQ20
        end else if (lightHit && !cmp.fbDroop) begin
            skipMode <= 1'b1; // RQ17
        end
    end

    // Falling feedback crossing the reference launches a pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fbBelowRefPrev <= 1'b0;
        end else begin
            fbBelowRefPrev <= cmp.fbBelowRef;
        end
    end

    assign refCross = cmp.fbBelowRef && !fbBelowRefPrev;

    // Time since last pulse; restarted by every launch or forced cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skipTimer <= '0;
        end else if (!skipMode || refCross || skipTimeout) begin
            skipTimer <= '0;
        end else begin
            skipTimer <= skipTimer + SKIP_TMR_W'(1);
        end
    end

    // A crossing in the timeout cycle wins, so no double pulse occurs
    assign skipTimeout = skipMode && !refCross && (skipTimer == SKIP_LIMIT - SKIP_TMR_W'(1));

    // One-cycle pulse requests; none once the run ends, so a trip never switches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            skipPulseLaunch <= 1'b0;
            skipForceSink   <= 1'b0;
        end else begin
            skipPulseLaunch <= skipMode && refCross && (next_state == ST_RUN); // RQ18
            skipForceSink   <= skipTimeout && (next_state == ST_RUN); // RQ19 RQ24
        end
    end

endmodule // cfm_fault_mode_ctrl

// File: src/cfm_pkg.sv
package cfm_pkg;

    // Clock
    localparam int unsigned CLK_PERIOD_NS    = 25;

    // Consecutive-sample counts
    localparam int unsigned ILIM_CYCLES      = 16;
    localparam int unsigned UV_CYCLES        = 16;
    localparam int unsigned OV_CYCLES        = 2;
    localparam int unsigned LIGHT_CYCLES     = 8;

    // Skip-mode anti-audible timeout, longest time so rounded down
    localparam int unsigned SKIP_TIMEOUT_US  = 40;
    localparam int unsigned SKIP_TIMEOUT_CYC = (SKIP_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SKIP_TMR_W       = $clog2(SKIP_TIMEOUT_CYC + 1);

    // Analog comparator results, all synchronous levels except cycleEnd
    typedef struct packed {
        logic supplyLockout;   // Bias supply below lockout
        logic turnOnAbove;     // Enable pin above 1.35 V
        logic turnOnBelow;     // Enable pin below 1.1 V
        logic rampAbove1v0;    // Startup ramp reached 1.0 V
        logic fbUnder;         // Feedback below under-voltage threshold
        logic fbOver;          // Feedback above 115 % of reference
        logic fbBelowDisch;    // Feedback below 0.25 V
        logic fbAboveRedisch;  // Feedback above 0.5 V
        logic fbOutOfWindow;   // Feedback outside regulation window
        logic fbBelowRef;      // Feedback below reference level
        logic fbDroop;         // Output 1.5 % below regulation point
        logic phaseHigh;       // Phase node above about 0.7 V
        logic lowSideFullOn;   // Low-side switch fully enhanced
        logic currentLimit;    // Current limit hit this cycle
        logic cycleEnd;        // One-cycle strobe at end of switching cycle
        logic lightLoad;       // Load at or below half the ripple
        logic overTemp;        // Die at about 160 C
        logic tempRecovered;   // Die below 130 C
        logic pulseOnly;       // Mode select pin below 0.6 V
    } cfm_cmp_t;

    // Sticky record of what set the fault latch
    typedef struct packed {
        logic overCurrent;
        logic underVoltage;
        logic overVoltage;
        logic highSideShort;
        logic overTemp;
    } cfm_cause_t;

    localparam cfm_cause_t CAUSE_RESET = '0;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFTSTART,
        ST_RUN,
        ST_FAULT,
        ST_REARM
    } cfm_state_t;

    localparam cfm_state_t STATE_RESET = ST_OFF;

endpackage

// File: src/cfm_consec.sv
`timescale 1ns/1ps

// Counts consecutive samples on which cond holds; hit once COUNT is reached
module cfm_consec #(
    parameter int unsigned COUNT = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic clear,
    input  wire logic sample,
    input  wire logic cond,
    // Result
    output logic      hit
);

    localparam int unsigned CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LIMIT = CW'(COUNT);

    logic [CW-1:0] cnt;

    // Saturating run counter; any sample without cond restarts the run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clear) begin
            cnt <= '0;
        end else if (sample) begin
            if (!cond) begin
                cnt <= '0;
            end else if (cnt != LIMIT) begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    assign hit = (cnt == LIMIT);

endmodule // cfm_consec

// File: tb/cfm_en_model.sv
`timescale 1ns/1ps

// Enable pin network; hookup 0 ground, 1 tied to bias, 2 left open
module cfm_en_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Pin drive from the device
    input  wire logic       sinkEn,
    input  wire logic       pullupEn,
    input  wire logic [1:0] hookup,
    // Threshold comparators
    output logic            above,
    output logic            below
);
    // Pin level in 0.1 V steps
    int unsigned level;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            level <= 0;
        else if (hookup == 2'h0)
            level <= 0;
        else if (hookup == 2'h1)
            level <= 50;
        else if (sinkEn && level > 0)
            level <= level - 1;
        else if (pullupEn && !sinkEn && level < 50)
            level <= level + 1;
    end

    // Hysteresis between 1.1 V and 1.35 V
    assign above = level > 13;
    assign below = level < 11;
endmodule // cfm_en_model

// File: tb/cfm_fault_mode_ctrl_asserts.sv
`timescale 1ns/1ps

module cfm_fault_mode_ctrl_asserts
    import cfm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Comparators
    input  wire cfm_cmp_t   cmp,
    // Watched outputs
    input  wire logic       switchEnable,
    input  wire logic       lowSideDischarge,
    input  wire logic       rampDischarge,
    input  wire logic       faultLatch,
    input  wire cfm_cause_t faultCause,
    input  wire logic       faultArmed,
    input  wire logic       turnOnSinkEnable,
    input  wire logic       turnOnPullupEnable,
    input  wire logic       powerGoodFlagOe,
    input  wire logic       skipMode,
    input  wire logic       skipPulseLaunch,
    input  wire logic       skipForceSink
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since the last skip pulse
    int unsigned idleCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            idleCnt <= 0;
        else if (!skipMode || skipPulseLaunch || skipForceSink)
            idleCnt <= 0;
        else
            idleCnt <= idleCnt + 1;
    end

    sequence s_ov2;
        (switchEnable && cmp.fbOver)[*2];
    endsequence
    sequence s_light8;
        (faultArmed && cmp.lightLoad && !cmp.pulseOnly && !cmp.fbDroop)[*8];
    endsequence

    property p_ov; s_ov2 |-> ##[0:2] faultLatch; endproperty
    a_ov: assert property (p_ov) else $error("over-voltage not latched");
    property p_short; switchEnable && cmp.phaseHigh && cmp.lowSideFullOn |=> faultLatch; endproperty
    a_short: assert property (p_short) else $error("short not latched");
    property p_uv; $rose(faultCause.underVoltage) |-> $past(faultArmed); endproperty
    a_uv: assert property (p_uv) else $error("under-voltage during soft-start");
    property p_off; faultLatch |-> !switchEnable && !skipMode && !skipPulseLaunch; endproperty
    a_off: assert property (p_off) else $error("switching while latched");
    property p_dis; faultLatch && cmp.fbBelowDisch && !cmp.fbAboveRedisch |=> !lowSideDischarge;
    endproperty
    a_dis: assert property (p_dis) else $error("discharge below threshold");
    property p_pgArm; !faultArmed |-> powerGoodFlagOe; endproperty
    a_pgArm: assert property (p_pgArm) else $error("power good before arming");
    property p_pgWin; cmp.fbOutOfWindow |=> powerGoodFlagOe; endproperty
    a_pgWin: assert property (p_pgWin) else $error("power good out of window");
    property p_skipIn; s_light8 |-> ##[0:2] skipMode; endproperty
    a_skipIn: assert property (p_skipIn) else $error("skip mode not entered");
    property p_pwmOnly; cmp.pulseOnly |=> !skipMode; endproperty
    a_pwmOnly: assert property (p_pwmOnly) else $error("skip with pulse-only");
    property p_skipArm; skipMode |-> faultArmed; endproperty
    a_skipArm: assert property (p_skipArm) else $error("skip before arming");
    property p_launch;
        skipMode && !cmp.fbDroop && !cmp.pulseOnly && $rose(cmp.fbBelowRef)
            |-> ##[0:2] skipPulseLaunch;
    endproperty
    a_launch: assert property (p_launch) else $error("skip pulse missing");
    property p_force; skipMode |-> idleCnt <= SKIP_TIMEOUT_CYC + 3; endproperty
    a_force: assert property (p_force) else $error("forced cycle late");
    property p_lock; cmp.supplyLockout |=> rampDischarge && !switchEnable && !faultLatch;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout did not reset");
    property p_sink; turnOnSinkEnable |-> faultLatch && !turnOnPullupEnable; endproperty
    a_sink: assert property (p_sink) else $error("enable sink outside fault");
endmodule // cfm_fault_mode_ctrl_asserts

bind cfm_fault_mode_ctrl cfm_fault_mode_ctrl_asserts chk (
    .clk(clk), .rst_n(rst_n), .cmp(cmp), .switchEnable(switchEnable),
    .lowSideDischarge(lowSideDischarge), .rampDischarge(rampDischarge),
    .faultLatch(faultLatch), .faultCause(faultCause), .faultArmed(faultArmed),
    .turnOnSinkEnable(turnOnSinkEnable), .turnOnPullupEnable(turnOnPullupEnable),
    .powerGoodFlagOe(powerGoodFlagOe), .skipMode(skipMode),
    .skipPulseLaunch(skipPulseLaunch), .skipForceSink(skipForceSink)
);

// File: tb/tb_cfm_fault_mode_ctrl.sv
`timescale 1ns/1ps

module tb_cfm_fault_mode_ctrl;
    import cfm_pkg::*;
    logic       clk, rst_n, enAbove, enBelow;
    logic [1:0] hookup;
    cfm_cmp_t   drv, cmp;
    cfm_cause_t cause;
    logic       swEn, lsDis, rampDis, latch, armed, sinkEn, pullEn;
    logic       pgOut, pgOe, skip, launch, forceSink;
    int         numErrors, checked, n, hits;

    // Enable bits from the pin model
    always_comb begin
        cmp = drv;
        cmp.turnOnAbove = enAbove;
        cmp.turnOnBelow = enBelow;
    end

    cfm_fault_mode_ctrl uut (
        .clk(clk), .rst_n(rst_n), .cmp(cmp), .switchEnable(swEn), .lowSideDischarge(lsDis),
        .rampDischarge(rampDis), .faultLatch(latch), .faultCause(cause), .faultArmed(armed),
        .turnOnSinkEnable(sinkEn), .turnOnPullupEnable(pullEn), .powerGoodFlagOut(pgOut),
        .powerGoodFlagOe(pgOe), .skipMode(skip), .skipPulseLaunch(launch),
        .skipForceSink(forceSink)
    );
    cfm_en_model enNet (
        .clk(clk), .rst_n(rst_n), .sinkEn(sinkEn), .pullupEn(pullEn), .hookup(hookup),
        .above(enAbove), .below(enBelow)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic reportAndStop;
        if (numErrors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int cyc);
        repeat (cyc) @(negedge clk);
    endtask

    function automatic cfm_cmp_t quiet();
        quiet = '0;
        quiet.tempRecovered = 1'b1;
    endfunction

    // Expected cause: one bit
    function automatic cfm_cause_t onlyCause(input int b);
        onlyCause = CAUSE_RESET;
        onlyCause[b] = 1'b1;
    endfunction

    // Optional lockout, bounded wait for soft-start
    task automatic restart(input bit lock);
        int i;
        drv = quiet();
        drv.supplyLockout = lock;
        tick(2);
        if (lock)
            check("rampDischarge", rampDis, 1);
        drv.supplyLockout = 1'b0;
        for (i = 0; i < 300 && swEn !== 1'b1; i++)
            tick(1);
        if (i == 300) begin
            numErrors++;
            reportAndStop();
        end
        check("faultLatch", latch, 0);
        check("faultArmed", armed, 0);
        check("pgOe", pgOe, 1);
    endtask
    task automatic arm;
        drv.rampAbove1v0 = 1'b1;
        tick(3);
        check("faultArmed", armed, 1);
        check("pgOe", pgOe, 0);
        drv.fbOutOfWindow = 1'b1;
        tick(2);
        check("pgOe", pgOe, 1);
        drv.fbOutOfWindow = 1'b0;
        tick(2);
    endtask
    task automatic expectTrip(input int b);
        tick(2);
        check("faultLatch", latch, 1);
        check("switchEnable", swEn, 0);
        check("faultCause", cause, onlyCause(b));
    endtask
    task automatic strobe(input bit lim);
        drv.currentLimit = lim;
        drv.cycleEnd = 1'b1;
        tick(1);
        drv.cycleEnd = 1'b0;
        tick($urandom_range(3, 1));
    endtask

    // Counts launch (0) or forced (1) pulses
    task automatic count(input int cyc, input bit sel);
        hits = 0;
        repeat (cyc) begin
            tick(1);
            hits += sel ? int'(forceSink) : int'(launch);
        end
    endtask

    initial begin
        drv = quiet();
        hookup = 2'h2;
        rst_n = 1'b0;
        numErrors = 0;
        checked = 0;
        void'($urandom(45));
        tick(2);
        check("pullup", pullEn, 1);
        check("pgOut", pgOut, 0);
        rst_n = 1'b1;
        // Over-voltage glitch, trip, discharge, restart
        restart(1);
        arm();
        drv.fbOver = 1'b1;
        tick(1);
        drv.fbOver = 1'b0;
        tick(3);
        check("faultLatch", latch, 0);
        drv.fbOver = 1'b1;
        tick(2);
        drv.fbOver = 1'b0;
        expectTrip(2);
        check("lowSideDischarge", lsDis, 1);
        check("sink", sinkEn, 1);
        drv.fbBelowDisch = 1'b1;
        tick(2);
        check("lowSideDischarge", lsDis, 0);
        drv.fbBelowDisch = 1'b0;
        tick(2);
        check("lowSideDischarge", lsDis, 0);
        drv.fbAboveRedisch = 1'b1;
        tick(2);
        check("lowSideDischarge", lsDis, 1);
        restart(0);
        check("faultCause", cause, CAUSE_RESET);
        check("pullup", pullEn, 1);
        // Over-temperature, pin tied high, released while hot
        hookup = 2'h1;
        restart(1);
        arm();
        drv.overTemp = 1'b1;
        drv.tempRecovered = 1'b0;
        tick(1);
        drv.overTemp = 1'b0;
        expectTrip(0);
        tick(60);
        check("faultLatch", latch, 1);
        hookup = 2'h2;
        tick(100);
        check("switchEnable", swEn, 0);
        drv.tempRecovered = 1'b1;
        restart(0);
        // Soft-start: under-voltage blanked, current limit counted
        restart(1);
        drv.fbUnder = 1'b1;
        tick(30);
        drv.fbUnder = 1'b0;
        check("faultLatch", latch, 0);
        repeat (15) strobe(1);
        strobe(0);
        check("faultLatch", latch, 0);
        repeat (16) strobe(1);
        expectTrip(4);
        // Shorted high side during soft-start
        restart(1);
        drv.phaseHigh = 1'b1;
        tick(3);
        check("faultLatch", latch, 0);
        drv.lowSideFullOn = 1'b1;
        tick(1);
        drv = quiet();
        expectTrip(1);
        // Under-voltage in run: short run, then sixteen
        restart(1);
        arm();
        n = $urandom_range(15, 1);
        drv.fbUnder = 1'b1;
        tick(n);
        drv.fbUnder = 1'b0;
        tick(3);
        check("faultLatch", latch, 0);
        drv.fbUnder = 1'b1;
        tick(16);
        drv.fbUnder = 1'b0;
        expectTrip(3);
        // Light-load skip mode
        restart(1);
        arm();
        drv.lightLoad = 1'b1;
        tick(7);
        drv.lightLoad = 1'b0;
        tick(3);
        check("skipMode", skip, 0);
        drv.pulseOnly = 1'b1;
        drv.lightLoad = 1'b1;
        tick(12);
        check("skipMode", skip, 0);
        drv.pulseOnly = 1'b0;
        tick(12);
        check("skipMode", skip, 1);
        drv.fbBelowRef = 1'b1;
        count(4, 0);
        check("launches", hits, 1);
        drv.fbBelowRef = 1'b0;
        count(SKIP_TIMEOUT_CYC - 15, 1);
        check("early forced cycle", hits, 0);
        count(25, 1);
        check("forced cycle", hits, 1);
        drv.fbDroop = 1'b1;
        tick(2);
        check("skipMode", skip, 0);
        // Grounded pin stops it
        hookup = 2'h0;
        tick(4);
        check("switchEnable", swEn, 0);
        check("rampDischarge", rampDis, 1);
        reportAndStop();
    end
endmodule // tb_cfm_fault_mode_ctrl
